//--- sbw_host_model.sv
// Host model driving the decoded register port of the supervisor block.
`timescale 1ns/10ps
module sbw_host_model
(
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    output logic reg_write,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial
    begin
        reg_write = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end

    // Data is inverted once the strobe drops, so nothing leans on a stale byte.
    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        reg_wdata <= ~data;
    endtask

    task automatic rd(input logic [6:0] addr, output logic [7:0] data);
        @(posedge clk_sys);
        reg_addr <= addr;
        @(posedge clk_sys);
        #1 data = reg_rdata;
    endtask
endmodule

//--- sbw_map.svh
// Register map, field positions, codes and timing constants of the supervisor block.
// Notes on behaviour
// [R1] Cause codes for power-on and sleep wake-ups.
// [R2] Cause codes for supervision overflow and early trigger.
// [R3] Cause codes for reset line, overheat, undervoltage, sleep.
// [R4] Status bit 6 mirrors overheat warning level.
// [R5] Status bit 5 set until Normal entered.
// [R6] Window supervision only in Normal; in-window trigger restarts.
// [R7] Timeout supervision runs; any trigger restarts timer.
// [R8] Mode field 7:5 codes; timeout or autonomous default.
// [R9] Window code acts as timeout until Normal.
// [R10] Normal-mode reconfiguration forces reset, cause 10000.
// [R11] Host reconfigures supervision only in Standby.
// [R12] Period field 3:0 selects eight periods.
// [R13] Period resets to the 128 ms code.
// [R14] Every valid control write is a trigger.
// [R15] New mode and period act immediately.
// [R16] Unlisted codes discard write, flag serial failure.
// [R17] Supervisor activity per chip mode and code.
// [R18] Forced normal or autonomous development: supervisor off.
// [R19] Config bit 3 forced normal, bit 2 development.
// [R20] Config bit 0 blocks sleep commands.
// [R21] Config bits 5:4 select startup undervoltage threshold.
// [R22] Window: early trigger or overflow resets system.
// [R23] Timeout overflow sets failure flag, resets, wakes.
// [R24] Reserved bits read zero, ignore writes.
`ifndef SBW_MAP_SVH
`define SBW_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define SBW_ADDR_CTRL 7'h00
`define SBW_ADDR_MAIN 7'h03
`define SBW_ADDR_NVCFG 7'h74

// ****************************************
// Field positions and masks
// ****************************************
`define SBW_MODE_HI 7
`define SBW_MODE_LO 5
`define SBW_PERIOD_HI 3
`define SBW_PERIOD_LO 0
`define SBW_NV_THR_HI 5
`define SBW_NV_THR_LO 4
`define SBW_NV_FORCED 3
`define SBW_NV_DEV 2
`define SBW_NV_SLEEP 0
`define SBW_NV_MASK 8'h3d
`define SBW_NV_RESET 8'h08

// ****************************************
// Supervision codes
// ****************************************
`define SBW_MODE_AUTO 3'h1
`define SBW_MODE_TIMEOUT 3'h2
`define SBW_MODE_WINDOW 3'h4
`define SBW_PER_8 4'h8
`define SBW_PER_16 4'h1
`define SBW_PER_32 4'h2
`define SBW_PER_64 4'hb
`define SBW_PER_128 4'h4
`define SBW_PER_256 4'hd
`define SBW_PER_1024 4'he
`define SBW_PER_4096 4'h7

// ****************************************
// Reset cause codes
// ****************************************
`define SBW_RC_POWER_ON 5'h00
`define SBW_RC_BUS_WAKE 5'h01
`define SBW_RC_PIN_WAKE 5'h04
`define SBW_RC_SLEEP_OVF 5'h0c
`define SBW_RC_DIAG_WAKE 5'h0d
`define SBW_RC_EARLY 5'h0e
`define SBW_RC_OVERFLOW 5'h0f
`define SBW_RC_ILLEGAL_CFG 5'h10
`define SBW_RC_LINE_LOW 5'h11
`define SBW_RC_OVERHEAT 5'h12
`define SBW_RC_UNDERVOLT 5'h13
`define SBW_RC_ILLEGAL_SLEEP 5'h14
`define SBW_RC_FRAME_WAKE 5'h16

// ****************************************
// Timing
// ****************************************
`define SBW_MS_NS 1000000
`define SBW_CLK_NS 20

`endif

//--- sbw_pkg.sv
// Types shared by the supervisor block.
package sbw_pkg;

    typedef enum logic [2:0]
    {
        SBW_CHIP_OFF = 3'h0,
        SBW_CHIP_SLEEP = 3'h1,
        SBW_CHIP_RESET = 3'h2,
        SBW_CHIP_OVERTEMP = 3'h3,
        SBW_CHIP_STANDBY = 3'h4,
        SBW_CHIP_FORCED = 3'h6,
        SBW_CHIP_NORMAL = 3'h7
    } sbw_chip_mode_type;

endpackage

//--- sbw_timer.sv
// Supervision period timer with millisecond prescaler and half-period flag.
`timescale 1ns/10ps
module sbw_timer
#(
    parameter int CYCLES_PER_MS = 50000,
    parameter int MS_WIDTH = 13
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic restart,
    input wire logic [MS_WIDTH-1:0] period_ms,
    output logic first_half,
    output logic overflow
);

    logic [31:0] prescale;
    logic [MS_WIDTH-1:0] elapsed_ms;
    logic tick;
    logic last_ms;

    assign tick = (prescale == 32'(CYCLES_PER_MS - 1));
    assign last_ms = (elapsed_ms == period_ms - MS_WIDTH'(1));
    assign first_half = (elapsed_ms < (period_ms >> 1));

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            prescale <= 32'h0;
        else if (restart || !enable || tick)
            prescale <= 32'h0;
        else
            prescale <= prescale + 32'h1;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            elapsed_ms <= '0;
        else if (restart || !enable)
            elapsed_ms <= '0;
        else if (tick)
            elapsed_ms <= last_ms ? '0 : elapsed_ms + MS_WIDTH'(1);
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            overflow <= 1'b0;
        else
            overflow <= enable && !restart && tick && last_ms;
    end

endmodule

//--- sbw_watchdog.sv
// Watchdog supervisor, configuration registers and reset cause reporting.
`timescale 1ns/10ps
`include "sbw_map.svh"
module sbw_watchdog
#(
    parameter int CYCLES_PER_MS = `SBW_MS_NS / `SBW_CLK_NS,
    parameter int MS_WIDTH = 13
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [2:0] chip_mode,
    input wire logic rxd_wake_pending,
    input wire logic overheat_warning_level,
    input wire logic reg_write,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic serial_failure_enable,
    input wire logic failure_flag_clear,
    input wire logic ev_bus_wake,
    input wire logic ev_pin_wake,
    input wire logic ev_diag_wake,
    input wire logic ev_frame_error_wake,
    input wire logic ev_reset_line_low,
    input wire logic ev_overtemp_exit,
    input wire logic ev_regulator_undervoltage,
    input wire logic ev_illegal_sleep,
    input wire logic sleep_request,
    output logic [7:0] reg_rdata,
    output logic system_reset_request,
    output logic wake_request,
    output logic serial_failure_event,
    output logic supervision_failure_flag,
    output logic sleep_accept,
    output logic forced_normal_state,
    output logic development_state,
    output logic [1:0] regulator_threshold_select
);

    // ****************************************
    // Code decoding
    // ****************************************
    function automatic logic mode_ok(input logic [2:0] code);
        mode_ok = (code == `SBW_MODE_AUTO) || (code == `SBW_MODE_TIMEOUT)
            || (code == `SBW_MODE_WINDOW);
    endfunction

    function automatic logic [MS_WIDTH-1:0] period_ms_of(input logic [3:0] code);
        case (code)
            `SBW_PER_8: period_ms_of = MS_WIDTH'(8);
            `SBW_PER_16: period_ms_of = MS_WIDTH'(16);
            `SBW_PER_32: period_ms_of = MS_WIDTH'(32);
            `SBW_PER_64: period_ms_of = MS_WIDTH'(64);
            `SBW_PER_128: period_ms_of = MS_WIDTH'(128);
            `SBW_PER_256: period_ms_of = MS_WIDTH'(256);
            `SBW_PER_1024: period_ms_of = MS_WIDTH'(1024);
            `SBW_PER_4096: period_ms_of = MS_WIDTH'(4096);
            default: period_ms_of = '0;
        endcase
    endfunction

    // ****************************************
    // Registers and internal state
    // ****************************************
    logic [2:0] supervision_mode_select;
    logic [3:0] supervision_period_select;
    logic [7:0] nv_config;
    logic [4:0] reset_cause;
    logic normal_entered_flag;
    logic overheat_meta;
    logic overheat_warning_flag;
    sbw_pkg::sbw_chip_mode_type mode_now;
    sbw_pkg::sbw_chip_mode_type mode_last;

    logic forced_normal_enable;
    logic development_mode_enable;
    logic sleep_command_block;
    logic in_normal;
    logic in_standby;
    logic in_sleep;
    logic active;
    logic window_form;
    logic ctrl_write;
    logic ctrl_codes_ok;
    logic ctrl_changed;
    logic illegal_change;
    logic early_trigger;
    logic trigger;
    logic codes_rejected;
    logic timer_first_half;
    logic timer_overflow;
    logic overflow_reset;
    logic sleep_overflow;
    logic timer_restart;

    assign mode_now = sbw_pkg::sbw_chip_mode_type'(chip_mode);
    assign forced_normal_enable = nv_config[`SBW_NV_FORCED];
    assign development_mode_enable = nv_config[`SBW_NV_DEV];
    assign sleep_command_block = nv_config[`SBW_NV_SLEEP];
    assign in_normal = (mode_now == sbw_pkg::SBW_CHIP_NORMAL);
    assign in_standby = (mode_now == sbw_pkg::SBW_CHIP_STANDBY);
    assign in_sleep = (mode_now == sbw_pkg::SBW_CHIP_SLEEP);

    // ****************************************
    // Supervisor activity per chip mode
    // ****************************************
    always_comb
    begin
        active = 1'b0;
        window_form = 1'b0;
        if (!forced_normal_enable) // R18
        begin
            case (supervision_mode_select)
                `SBW_MODE_AUTO:
                begin
                    active = !development_mode_enable // R18
                        && (in_normal || (in_standby && rxd_wake_pending)); // R17
                end
                `SBW_MODE_TIMEOUT:
                begin
                    active = in_normal || in_standby || in_sleep; // R17 R7
                end
                `SBW_MODE_WINDOW:
                begin
                    active = in_normal || in_standby || in_sleep; // R17
                    window_form = in_normal; // R9 R6
                end
                default:
                begin
                    active = 1'b0;
                    window_form = 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Control register write decoding
    // ****************************************
    assign ctrl_write = reg_write && (reg_addr == `SBW_ADDR_CTRL);
    assign ctrl_codes_ok = mode_ok(reg_wdata[`SBW_MODE_HI:`SBW_MODE_LO])
        && (period_ms_of(reg_wdata[`SBW_PERIOD_HI:`SBW_PERIOD_LO]) != '0); // R16
    assign ctrl_changed = (reg_wdata[`SBW_MODE_HI:`SBW_MODE_LO] != supervision_mode_select)
        || (reg_wdata[`SBW_PERIOD_HI:`SBW_PERIOD_LO] != supervision_period_select);
    assign codes_rejected = ctrl_write && !ctrl_codes_ok; // R16
    // A host that keeps reconfiguration to Standby never reaches this path.
    assign illegal_change = ctrl_write && ctrl_codes_ok && ctrl_changed && in_normal; // R10 R11
    assign early_trigger = ctrl_write && ctrl_codes_ok && !illegal_change
        && active && window_form && timer_first_half; // R22
    assign trigger = ctrl_write && ctrl_codes_ok && !illegal_change && !early_trigger; // R14

    // Overflow while already in window form, or with the failure flag pending, resets.
    assign overflow_reset = timer_overflow && (window_form || supervision_failure_flag); // R22 R23
    assign sleep_overflow = timer_overflow && !overflow_reset && in_sleep; // R23

    // Restarting on a chip mode change keeps a stale count from the
    // previous form from cutting the first window short.
    assign timer_restart = trigger || early_trigger || illegal_change
        || (mode_now != mode_last) || system_reset_request; // R14 R15

    sbw_timer
    #(
        .CYCLES_PER_MS(CYCLES_PER_MS),
        .MS_WIDTH(MS_WIDTH)
    )
    u_timer
    (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .enable(active),
        .restart(timer_restart),
        .period_ms(period_ms_of(supervision_period_select)), // R12
        .first_half(timer_first_half),
        .overflow(timer_overflow)
    );

    // ****************************************
    // Supervision control register
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            supervision_mode_select <= `SBW_MODE_TIMEOUT; // R8
            supervision_period_select <= `SBW_PER_128; // R13
        end
        else if (mode_now == sbw_pkg::SBW_CHIP_RESET)
        begin
            // Defaults are reloaded while the chip sits in Reset mode.
            supervision_mode_select <= development_mode_enable
                ? `SBW_MODE_AUTO : `SBW_MODE_TIMEOUT; // R8
            supervision_period_select <= `SBW_PER_128; // R13
        end
        else if (trigger || early_trigger)
        begin
            supervision_mode_select <= reg_wdata[`SBW_MODE_HI:`SBW_MODE_LO]; // R15
            supervision_period_select <= reg_wdata[`SBW_PERIOD_HI:`SBW_PERIOD_LO]; // R12 R15
        end
    end

    // ****************************************
    // Non-volatile configuration register
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            nv_config <= `SBW_NV_RESET; // R19 R20 R21
        else if (reg_write && (reg_addr == `SBW_ADDR_NVCFG))
            nv_config <= reg_wdata & `SBW_NV_MASK; // R24
    end

    // ****************************************
    // Status flags
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            overheat_meta <= 1'b0;
            overheat_warning_flag <= 1'b0;
        end
        else
        begin
            overheat_meta <= overheat_warning_level;
            overheat_warning_flag <= overheat_meta; // R4
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            normal_entered_flag <= 1'b1; // R5
        else if (in_normal)
            normal_entered_flag <= 1'b0; // R5
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            mode_last <= sbw_pkg::SBW_CHIP_OFF;
        else
            mode_last <= mode_now;
    end

    // A fresh overflow outside window form wins over a clear arriving in the same cycle.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            supervision_failure_flag <= 1'b0;
        else if (timer_overflow && !window_form)
            supervision_failure_flag <= 1'b1; // R23
        else if (failure_flag_clear)
            supervision_failure_flag <= 1'b0;
    end

    // ****************************************
    // Reset cause capture
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            reset_cause <= `SBW_RC_POWER_ON; // R1
        else if (illegal_change)
            reset_cause <= `SBW_RC_ILLEGAL_CFG; // R10
        else if (early_trigger)
            reset_cause <= `SBW_RC_EARLY; // R2
        else if (overflow_reset)
            reset_cause <= `SBW_RC_OVERFLOW; // R2
        else if (sleep_overflow)
            reset_cause <= `SBW_RC_SLEEP_OVF; // R2
        else if (ev_regulator_undervoltage)
            reset_cause <= `SBW_RC_UNDERVOLT; // R3
        else if (ev_overtemp_exit)
            reset_cause <= `SBW_RC_OVERHEAT; // R3
        else if (ev_reset_line_low)
            reset_cause <= `SBW_RC_LINE_LOW; // R3
        else if (ev_illegal_sleep)
            reset_cause <= `SBW_RC_ILLEGAL_SLEEP; // R3
        else if (ev_bus_wake)
            reset_cause <= `SBW_RC_BUS_WAKE; // R1
        else if (ev_pin_wake)
            reset_cause <= `SBW_RC_PIN_WAKE; // R1
        else if (ev_diag_wake)
            reset_cause <= `SBW_RC_DIAG_WAKE; // R1
        else if (ev_frame_error_wake)
            reset_cause <= `SBW_RC_FRAME_WAKE; // R1
    end

    // ****************************************
    // Event outputs
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            system_reset_request <= 1'b0;
            wake_request <= 1'b0;
            serial_failure_event <= 1'b0;
            sleep_accept <= 1'b0;
        end
        else
        begin
            system_reset_request <= illegal_change || early_trigger || overflow_reset; // R10 R22 R23
            wake_request <= sleep_overflow; // R23
            serial_failure_event <= serial_failure_enable
                && (codes_rejected || illegal_change); // R16 R10
            sleep_accept <= sleep_request && !sleep_command_block; // R20
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            forced_normal_state <= 1'b1;
            development_state <= 1'b0;
            regulator_threshold_select <= 2'h0;
        end
        else
        begin
            forced_normal_state <= forced_normal_enable; // R19
            development_state <= development_mode_enable; // R19
            regulator_threshold_select <= nv_config[`SBW_NV_THR_HI:`SBW_NV_THR_LO]; // R21
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else
        begin
            case (reg_addr)
                `SBW_ADDR_CTRL:
                    reg_rdata <= {supervision_mode_select, 1'b0, supervision_period_select}; // R24
                `SBW_ADDR_MAIN:
                    reg_rdata <= {1'b0, overheat_warning_flag, normal_entered_flag,
                        reset_cause}; // R4 R5 R24
                `SBW_ADDR_NVCFG:
                    reg_rdata <= nv_config; // R24
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

//--- sbw_watchdog_checker.sv
// Port-level assertions for the supervisor block, bound to its top module.
`timescale 1ns/10ps
module sbw_checker
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [2:0] chip_mode,
    input wire logic overheat_warning_level,
    input wire logic reg_write,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic serial_failure_enable,
    input wire logic failure_flag_clear,
    input wire logic sleep_request,
    input wire logic [7:0] reg_rdata,
    input wire logic system_reset_request,
    input wire logic wake_request,
    input wire logic supervision_failure_flag,
    input wire logic serial_failure_event,
    input wire logic sleep_accept,
    input wire logic forced_normal_state,
    input wire logic development_state,
    input wire logic [1:0] regulator_threshold_select
);
    // ********************
    // Assertions
    // ********************
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    nv_copy_a: assert property (reg_write && reg_addr == 7'h74 |-> ##2
        {forced_normal_state, development_state, regulator_threshold_select}
        == {$past(reg_wdata[3:2], 2), $past(reg_wdata[5:4], 2)}) else $error("config copy wrong");
    sleep_gate_a: assert property (sleep_accept |-> $past(sleep_request))
        else $error("sleep accepted unasked");
    bad_code_a: assert property (reg_write && reg_addr == 7'h00 && serial_failure_enable
        && !(reg_wdata[7:5] inside {3'h1, 3'h2, 3'h4}) |=> serial_failure_event)
        else $error("bad mode code not flagged");
    reserved_zero_a: assert property (!($past(reg_addr) == 7'h03 && reg_rdata[7]
        || $past(reg_addr) == 7'h00 && reg_rdata[4]
        || $past(reg_addr) == 7'h74 && (reg_rdata[7:6] != 2'h0 || reg_rdata[1])))
        else $error("reserved bit set");
    heat_status_a: assert property ((reg_addr == 7'h03 && overheat_warning_level)[*3]
        |=> reg_rdata[6]) else $error("overheat status missing");
    sleep_wake_a: assert property (wake_request |-> $past(chip_mode) == 3'h1)
        else $error("wake outside sleep");
    flag_hold_a: assert property (supervision_failure_flag && !failure_flag_clear
        |=> supervision_failure_flag) else $error("failure flag dropped");
    forced_quiet_a: assert property (forced_normal_state && $past(forced_normal_state)
        |-> !$rose(supervision_failure_flag) && !wake_request) else $error("supervisor ran");
    active_mode_a: assert property (system_reset_request || $rose(supervision_failure_flag)
        |-> $past(chip_mode) inside {3'h1, 3'h4, 3'h7}) else $error("supervisor active");
endmodule

bind sbw_watchdog sbw_checker u_checker
(
    .clk_sys(clk_sys), .arst_n(arst_n), .chip_mode(chip_mode),
    .overheat_warning_level(overheat_warning_level), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .serial_failure_enable(serial_failure_enable),
    .failure_flag_clear(failure_flag_clear), .sleep_request(sleep_request),
    .reg_rdata(reg_rdata), .system_reset_request(system_reset_request),
    .wake_request(wake_request), .supervision_failure_flag(supervision_failure_flag),
    .serial_failure_event(serial_failure_event), .sleep_accept(sleep_accept),
    .forced_normal_state(forced_normal_state), .development_state(development_state),
    .regulator_threshold_select(regulator_threshold_select)
);

//--- test_sbc_watchdog_reset_status.sv
// Self-checking testbench for the supervisor block.
`timescale 1ns/10ps
module test_sbc_watchdog_reset_status;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] chip_mode = 3'h4;
    logic overheat_warning_level = 1'b0;
    logic serial_failure_enable = 1'b0;
    logic failure_flag_clear = 1'b0;
    logic sleep_request = 1'b0;
    logic rxd_wake_pending = 1'b0;
    logic [7:0] ev = 8'h00;
    logic reg_write;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic system_reset_request;
    logic wake_request;
    logic serial_failure_event;
    logic supervision_failure_flag;
    logic sleep_accept;
    logic forced_normal_state;
    logic development_state;
    logic [1:0] regulator_threshold_select;
    logic [2:0] outs;
    logic [7:0] d;
    logic [3:0] per [8] = '{4'h8, 4'h1, 4'h2, 4'hb, 4'h4, 4'hd, 4'he, 4'h7};
    logic [2:0] modes [3] = '{3'h1, 3'h2, 3'h4};
    logic [4:0] codes [8] = '{5'h01, 5'h04, 5'h0d, 5'h16, 5'h11, 5'h12, 5'h13, 5'h14};
    logic [7:0] bad [2] = '{8'h64, 8'h49};
    int errors = 0;
    int checks_done = 0;
    int n;

    assign outs = {wake_request, system_reset_request, supervision_failure_flag};

    // One millisecond is four clocks here, so an 8 ms period is 32 clocks.
    sbw_watchdog #(.CYCLES_PER_MS(4)) u_dut
    (
        .clk_sys(clk_sys), .arst_n(arst_n), .chip_mode(chip_mode),
        .overheat_warning_level(overheat_warning_level), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .serial_failure_enable(serial_failure_enable),
        .failure_flag_clear(failure_flag_clear), .ev_bus_wake(ev[0]), .ev_pin_wake(ev[1]),
        .ev_diag_wake(ev[2]), .ev_frame_error_wake(ev[3]), .ev_reset_line_low(ev[4]),
        .ev_overtemp_exit(ev[5]), .ev_regulator_undervoltage(ev[6]), .ev_illegal_sleep(ev[7]),
        .sleep_request(sleep_request), .reg_rdata(reg_rdata), .rxd_wake_pending(rxd_wake_pending),
        .system_reset_request(system_reset_request), .wake_request(wake_request),
        .serial_failure_event(serial_failure_event),
        .supervision_failure_flag(supervision_failure_flag), .sleep_accept(sleep_accept),
        .forced_normal_state(forced_normal_state), .development_state(development_state),
        .regulator_threshold_select(regulator_threshold_select)
    );

    sbw_host_model u_host
    (
        .clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata)
    );

    // ********************
    // Helpers
    // ********************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [6:0] addr, input logic [7:0] exp);
        u_host.rd(addr, d);
        chk(d, exp);
    endtask

    task automatic slp(input logic exp);
        @(posedge clk_sys);
        sleep_request <= 1'b1;
        @(posedge clk_sys);
        sleep_request <= 1'b0;
        #1 chk({7'h0, sleep_accept}, {7'h0, exp});
    endtask

    task automatic wait_on(input int sel, output int cnt);
        cnt = 0;
        while (outs[sel] !== 1'b1 && cnt < 300)
        begin
            @(posedge clk_sys);
            #1 cnt++;
        end
    endtask

    task automatic results();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
        forever #10 clk_sys = ~clk_sys;

    initial
    begin
        #200000;
        errors++;
        $display("ERROR %0t: run did not finish", $time);
        results();
    end

    // ********************
    // Tests
    // ********************
    initial
    begin
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        rchk(7'h00, 8'h44);
        rchk(7'h74, 8'h08);
        rchk(7'h03, 8'h20);
        chk({7'h0, forced_normal_state}, 8'h01);
        u_host.wr(7'h74, 8'hff);
        rchk(7'h74, 8'h3d);
        chk({5'h0, development_state, regulator_threshold_select}, 8'h07);
        slp(1'b0);
        u_host.wr(7'h74, 8'h00);
        slp(1'b1);
        chk({6'h0, forced_normal_state, development_state}, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            u_host.wr(7'h00, {modes[i % 3], 1'b0, per[i]});
            rchk(7'h00, {modes[i % 3], 1'b0, per[i]});
        end
        @(posedge clk_sys);
        serial_failure_enable <= 1'b1;
        rxd_wake_pending <= 1'b1;
        u_host.wr(7'h00, 8'h44);
        for (int i = 0; i < 2; i++)
        begin
            u_host.wr(7'h00, bad[i]);
            #1 chk({7'h0, serial_failure_event}, 8'h01);
            rchk(7'h00, 8'h44);
        end
        // Triggers every 22 clocks must keep a 32-clock period from ever running out.
        u_host.wr(7'h00, 8'h48);
        repeat (5)
        begin
            repeat (20) @(posedge clk_sys);
            u_host.wr(7'h00, 8'h48);
        end
        chk({7'h0, supervision_failure_flag}, 8'h00);
        u_host.wr(7'h00, 8'h44);
        u_host.wr(7'h00, 8'h28);
        wait_on(0, n);
        chk(8'(n > 30 && n < 37), 8'h01);
        wait_on(1, n);
        chk(8'(n > 29 && n < 37), 8'h01);
        rchk(7'h03, 8'h2f);
        u_host.wr(7'h00, 8'h48);
        failure_flag_clear <= 1'b1;
        chip_mode <= 3'h1;
        @(posedge clk_sys);
        failure_flag_clear <= 1'b0;
        wait_on(2, n);
        chk(8'(n > 29 && n < 37), 8'h01);
        chk({7'h0, supervision_failure_flag}, 8'h01);
        rchk(7'h03, 8'h2c);
        @(posedge clk_sys);
        chip_mode <= 3'h2;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_sys);
            ev <= 8'h01 << i;
            @(posedge clk_sys);
            ev <= 8'h00;
            rchk(7'h03, {3'h1, codes[i]});
        end
        @(posedge clk_sys);
        chip_mode <= 3'h4;
        u_host.wr(7'h00, 8'h88);
        u_host.wr(7'h00, 8'h88);
        #1 chk({7'h0, system_reset_request}, 8'h00);
        rchk(7'h00, 8'h88);
        @(posedge clk_sys);
        chip_mode <= 3'h7;
        u_host.wr(7'h00, 8'h88);
        #1 chk({7'h0, system_reset_request}, 8'h01);
        rchk(7'h03, 8'h0e);
        repeat (20) @(posedge clk_sys);
        u_host.wr(7'h00, 8'h88);
        wait_on(1, n);
        chk(8'(n > 29 && n < 37), 8'h01);
        u_host.wr(7'h00, 8'h48);
        #1 chk({6'h0, system_reset_request, serial_failure_event}, 8'h03);
        rchk(7'h03, 8'h10);
        rchk(7'h00, 8'h88);
        @(posedge clk_sys);
        chip_mode <= 3'h2;
        overheat_warning_level <= 1'b1;
        repeat (4) @(posedge clk_sys);
        repeat (2) rchk(7'h03, 8'h50);
        results();
    end
endmodule
